// file: hdl/tmrctl_top.sv
// Timer channel enable, run and start control with AHB-Lite register slave
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tmrctl_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // System state and pins
  input wire logic debug_halt_in,
  input wire logic idle_mode_in,
  input wire logic sync_start_in,
  input wire logic timer_input_pin_in,
  // Channel controls and state
  output logic channel_clk_en_out,
  output logic compare_buffered_out,
  output logic prescale_tick_out,
  output logic [CNT_W-1:0] count_out
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    tmrctl_pkg::tmrctl_regs_t regs;
    tmrctl_pkg::tmrctl_run_t run_st;
    logic [7:0] presc_cnt;
    logic tick;
    logic [CNT_W-1:0] count;
    logic clk_en;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
  } tmrctl_state_t;

  tmrctl_state_t st_r;
  tmrctl_state_t st_nxt;
  logic trig_edge;
  logic clk_on;
  logic ap_take;
  logic [7:0] ap_addr;

  // Channel clock gate: unit enable, halt and idle qualifiers
  assign clk_on = st_r.regs.unit_en
    && !(debug_halt_in && st_r.regs.halt_stop)
    && !(idle_mode_in && !st_r.regs.cr.idle_op);

  assign ap_take = hsel_in && hready_in && htrans_in[1];
  assign ap_addr = haddr_in[7:0];

  tmrctl_edge tmrctl_edge_inst (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .pin_in(timer_input_pin_in),
    .fall_sel_in(st_r.regs.cr.trg_fall),
    .clk_en_in(clk_on),
    .edge_out(trig_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic gated_ok;
    gated_ok = 1'b0;
    st_nxt = st_r;
    st_nxt.clk_en = clk_on;
    st_nxt.tick = 1'b0;

    // Address phase capture; data phase always completes in one cycle
    st_nxt.ph_valid = ap_take;
    st_nxt.ph_write = hwrite_in;
    st_nxt.ph_addr = ap_addr;
    st_nxt.rdata = 32'h0000_0000;
    // Other registers gated while disabled; their values simply hold
    gated_ok = st_r.regs.unit_en;

    // Write data phase
    if (st_r.ph_valid && st_r.ph_write) begin
      case (st_r.ph_addr)
        tmrctl_pkg::ADDR_ENABLE: begin
          st_nxt.regs.unit_en = hwdata_in[tmrctl_pkg::EN_UNIT_BIT];
          st_nxt.regs.halt_stop = hwdata_in[tmrctl_pkg::EN_HALT_BIT];
        end
        tmrctl_pkg::ADDR_RUN: begin
          if (gated_ok) begin
            st_nxt.regs.presc_run = hwdata_in[tmrctl_pkg::RUN_PRESC_BIT];
            st_nxt.regs.cnt_run = hwdata_in[tmrctl_pkg::RUN_CNT_BIT];
          end
        end
        tmrctl_pkg::ADDR_CONTROL: begin
          // Written regardless of run state; software keeps it stable while running
          if (gated_ok) begin
            st_nxt.regs.cr.wbf = hwdata_in[tmrctl_pkg::CR_WBF_BIT];
            st_nxt.regs.cr.sync = hwdata_in[tmrctl_pkg::CR_SYNC_BIT];
            st_nxt.regs.cr.idle_op = hwdata_in[tmrctl_pkg::CR_IDLE_BIT];
            st_nxt.regs.cr.trg_fall = hwdata_in[tmrctl_pkg::CR_TRG_BIT];
            st_nxt.regs.cr.css_ext = hwdata_in[tmrctl_pkg::CR_CSS_BIT];
          end
        end
        tmrctl_pkg::ADDR_PRESCALE: begin
          if (gated_ok) begin
            st_nxt.regs.presc_div = hwdata_in[7:0];
          end
        end
        default: begin
          st_nxt.regs = st_r.regs;
        end
      endcase
    end

    // Read sees a write still in its data phase, so back to back transfers get new data
    if (ap_take && !hwrite_in) begin
      case (ap_addr)
        tmrctl_pkg::ADDR_ENABLE: begin
          st_nxt.rdata[tmrctl_pkg::EN_UNIT_BIT] = st_nxt.regs.unit_en;
          st_nxt.rdata[tmrctl_pkg::EN_HALT_BIT] = st_nxt.regs.halt_stop;
        end
        tmrctl_pkg::ADDR_RUN: begin
          if (st_nxt.regs.unit_en) begin
            st_nxt.rdata[tmrctl_pkg::RUN_PRESC_BIT] = st_nxt.regs.presc_run;
            st_nxt.rdata[tmrctl_pkg::RUN_CNT_BIT] = st_nxt.regs.cnt_run;
          end
        end
        tmrctl_pkg::ADDR_CONTROL: begin
          if (st_nxt.regs.unit_en) begin
            st_nxt.rdata[tmrctl_pkg::CR_WBF_BIT] = st_nxt.regs.cr.wbf;
            st_nxt.rdata[tmrctl_pkg::CR_SYNC_BIT] = st_nxt.regs.cr.sync;
            st_nxt.rdata[tmrctl_pkg::CR_IDLE_BIT] = st_nxt.regs.cr.idle_op;
            st_nxt.rdata[tmrctl_pkg::CR_TRG_BIT] = st_nxt.regs.cr.trg_fall;
            st_nxt.rdata[tmrctl_pkg::CR_CSS_BIT] = st_nxt.regs.cr.css_ext;
          end
        end
        tmrctl_pkg::ADDR_PRESCALE: begin
          if (st_nxt.regs.unit_en) begin
            st_nxt.rdata[7:0] = st_nxt.regs.presc_div;
          end
        end
        tmrctl_pkg::ADDR_STATUS: begin
          if (st_nxt.regs.unit_en) begin
            st_nxt.rdata[CNT_W-1:0] = st_r.count;
          end
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Prescaler and counter advance only on the channel clock
    if (!st_r.regs.presc_run) begin
      st_nxt.presc_cnt = 8'h00;
    end else if (clk_on) begin
      if (st_r.presc_cnt >= st_r.regs.presc_div) begin
        st_nxt.presc_cnt = 8'h00;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.presc_cnt = st_r.presc_cnt + 8'h01;
      end
    end

    if (!st_r.regs.cnt_run) begin
      st_nxt.run_st = tmrctl_pkg::TMRCTL_IDLE;
      st_nxt.count = '0;
    end else if (clk_on) begin
      case (st_r.run_st)
        tmrctl_pkg::TMRCTL_IDLE: begin
          st_nxt.run_st = tmrctl_pkg::TMRCTL_ARMED;
        end
        tmrctl_pkg::TMRCTL_ARMED: begin
          // Start source: software, external edge, optionally a shared sync start
          if (st_r.regs.cr.css_ext ? trig_edge : 1'b1) begin
            if (!st_r.regs.cr.sync || sync_start_in) begin
              st_nxt.run_st = tmrctl_pkg::TMRCTL_COUNTING;
            end
          end
        end
        tmrctl_pkg::TMRCTL_COUNTING: begin
          if (st_r.tick) begin
            st_nxt.count = st_r.count + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          st_nxt.run_st = tmrctl_pkg::TMRCTL_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata_out = st_r.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign channel_clk_en_out = st_r.clk_en;
  assign compare_buffered_out = st_r.regs.cr.wbf;
  assign prescale_tick_out = st_r.tick;
  assign count_out = st_r.count;
endmodule : tmrctl_top
`default_nettype wire

// file: hdl/tmrctl_pkg.sv
// Package: register map, field positions, resets and carriers for the timer run control
package tmrctl_pkg;
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_RUN = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_PRESCALE = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam int EN_UNIT_BIT = 7;
  localparam int EN_HALT_BIT = 6;
  localparam int RUN_PRESC_BIT = 2;
  localparam int RUN_CNT_BIT = 0;
  localparam int CR_WBF_BIT = 7;
  localparam int CR_SYNC_BIT = 5;
  localparam int CR_IDLE_BIT = 3;
  localparam int CR_TRG_BIT = 1;
  localparam int CR_CSS_BIT = 0;
  localparam logic [31:0] EN_MASK = 32'h0000_00C0;
  localparam logic [31:0] RUN_MASK = 32'h0000_0005;
  localparam logic [31:0] CR_MASK = 32'h0000_00AB;
  localparam logic [31:0] PRESC_MASK = 32'h0000_00FF;
  localparam logic [7:0] PRESC_RESET = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    TMRCTL_IDLE,
    TMRCTL_ARMED,
    TMRCTL_COUNTING
  } tmrctl_run_t;

  typedef struct packed {
    logic wbf;
    logic sync;
    logic idle_op;
    logic trg_fall;
    logic css_ext;
  } tmrctl_cr_t;

  typedef struct packed {
    logic unit_en;
    logic halt_stop;
    logic presc_run;
    logic cnt_run;
    tmrctl_cr_t cr;
    logic [7:0] presc_div;
  } tmrctl_regs_t;
endpackage : tmrctl_pkg

// file: hdl/tmrctl_edge.sv
// Edge detector for the timer input pin with selectable polarity
`timescale 1ns/1ps
`default_nettype none
module tmrctl_edge (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Pin and control
  input wire logic pin_in,
  input wire logic fall_sel_in,
  input wire logic clk_en_in,
  output logic edge_out
);
  logic prev_r;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_r <= 1'b0;
    end else if (clk_en_in) begin
      prev_r <= pin_in;
    end
  end

  // Edge only counts while the channel clock runs
  assign edge_out = clk_en_in && (fall_sel_in ? (prev_r && !pin_in) : (!prev_r && pin_in));
endmodule : tmrctl_edge
`default_nettype wire

// file: tb/tmrctl_sva.sv
// Checker: bus read masks and channel gate properties of the timer run control
`timescale 1ns/1ps
`default_nettype none
module tmrctl_sva #(
  parameter int CNT_W = 16
) (
  // Clock, reset and bus
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  // Channel
  input wire logic debug_halt_in,
  input wire logic idle_mode_in,
  input wire logic channel_clk_en_out,
  input wire logic [CNT_W-1:0] count_out
);
  logic wr_r;
  logic en_r;
  wire logic rd_go = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  // Shadow of the unit enable bit, followed from bus writes
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_r <= 1'b0;
      en_r <= 1'b0;
    end else if (hready_in) begin
      wr_r <= hsel_in && htrans_in[1] && hwrite_in && haddr_in[7:0] == tmrctl_pkg::ADDR_ENABLE;
      if (wr_r) begin
        en_r <= hwdata_in[tmrctl_pkg::EN_UNIT_BIT];
      end
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  chk_en_spare: assert property (rd_go && haddr_in[7:0] == tmrctl_pkg::ADDR_ENABLE
    |=> (hrdata_out & ~tmrctl_pkg::EN_MASK) == 32'h0) else $error("enable spare bits set");
  chk_run_spare: assert property (rd_go && haddr_in[7:0] == tmrctl_pkg::ADDR_RUN
    |=> (hrdata_out & ~tmrctl_pkg::RUN_MASK) == 32'h0) else $error("run spare bits set");
  chk_cr_spare: assert property (rd_go && haddr_in[7:0] == tmrctl_pkg::ADDR_CONTROL
    |=> (hrdata_out & ~tmrctl_pkg::CR_MASK) == 32'h0) else $error("control spare bits set");
  chk_unmapped_zero: assert property (rd_go && haddr_in[7:0] == 8'h40
    |=> hrdata_out == 32'h0) else $error("unmapped read not zero");
  chk_gate_off: assert property (!en_r |=> !channel_clk_en_out)
    else $error("clock on while disabled");
  chk_gate_on: assert property (en_r && !debug_halt_in && !idle_mode_in
    |=> channel_clk_en_out) else $error("clock off while enabled");
  chk_count_hold: assert property (!channel_clk_en_out [*2]
    |=> $stable(count_out)) else $error("count moved while gated");
  chk_count_step: assert property ($changed(count_out)
    |-> count_out == $past(count_out) + 1'b1 || !(|count_out)) else $error("count jumped");
endmodule : tmrctl_sva
bind tmrctl_top tmrctl_sva #(.CNT_W(CNT_W)) tmrctl_sva_inst (.mclk_in, .arst_n_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .debug_halt_in,
  .idle_mode_in, .channel_clk_en_out, .count_out);
`default_nettype wire

// file: tb/tmrctl_tb.sv
// Testbench: register access, run control and start modes of the timer channel
`timescale 1ns/1ps
`default_nettype none
module tmrctl_tb;
  localparam logic [7:0] A_EN = tmrctl_pkg::ADDR_ENABLE;
  localparam logic [7:0] A_RUN = tmrctl_pkg::ADDR_RUN;
  localparam logic [7:0] A_CR = tmrctl_pkg::ADDR_CONTROL;
  logic mclk_in = 1'b0, arst_n_in = 1'b0, hsel_in = 1'b1, hwrite_in = 1'b0;
  logic debug_halt_in = 1'b0, idle_mode_in = 1'b0, sync_start_in = 1'b0;
  logic timer_input_pin_in = 1'b0, hready_in, hreadyout_out, hresp_out;
  logic channel_clk_en_out, compare_buffered_out, prescale_tick_out;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = tmrctl_pkg::HSIZE_WORD;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, r;
  logic [15:0] count_out, c0;
  int error_cnt = 0, checks_done = 0;
  assign hready_in = hreadyout_out;
  always #5 mclk_in = ~mclk_in;
  tmrctl_top #(.CNT_W(16)) tmrctl_top_inst (.mclk_in, .arst_n_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out,
    .hresp_out, .debug_halt_in, .idle_mode_in, .sync_start_in, .timer_input_pin_in,
    .channel_clk_en_out, .compare_buffered_out, .prescale_tick_out, .count_out);
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Each phase held until hready, so a slower slave still works
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    htrans_in <= tmrctl_pkg::HTRANS_NONSEQ;
    hwrite_in <= w;
    haddr_in <= {24'h0, a};
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    r = hrdata_out;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rd
  task automatic rate(input int n, input logic [15:0] e);
    c0 = count_out;
    cyc(n);
    chk(count_out - c0, e);
  endtask : rate
  task automatic t_regs();
    rd(A_EN, 32'h0);
    bus(1'b1, A_RUN, 32'h5);
    rd(A_RUN, 32'h0);
    bus(1'b1, A_EN, 32'hFFFF_FFFF);
    rd(A_EN, 32'hC0);
    rd(A_RUN, 32'h0);
    rd(8'h40, 32'h0);
    chk({30'h0, hreadyout_out, hresp_out}, 32'h2);
    bus(1'b1, A_EN, 32'h80);
    bus(1'b1, A_CR, 32'hFFFF_FFFF);
    rd(A_CR, 32'hAB);
    bus(1'b1, A_CR, 32'h88);
    cyc(2);
    chk(compare_buffered_out, 32'h1);
    bus(1'b1, A_EN, 32'h0);
    rd(A_CR, 32'h0);
    bus(1'b1, A_EN, 32'h80);
    rd(A_CR, 32'h88);
  endtask : t_regs
  task automatic t_run();
    bus(1'b1, A_RUN, 32'h5);
    cyc(4);
    rate(10, 16'hA);
    chk(prescale_tick_out, 32'h1);
    idle_mode_in <= 1'b1;
    debug_halt_in <= 1'b1;
    cyc(3);
    chk(channel_clk_en_out, 32'h1);
    bus(1'b1, A_EN, 32'hC0);
    cyc(2);
    chk(channel_clk_en_out, 32'h0);
    rate(10, 16'h0);
    idle_mode_in <= 1'b0;
    debug_halt_in <= 1'b0;
    bus(1'b1, A_EN, 32'h80);
    bus(1'b1, tmrctl_pkg::ADDR_PRESCALE, 32'h1);
    cyc(4);
    rate(20, 16'hA);
    bus(1'b1, A_RUN, 32'h1);
    cyc(3);
    rate(10, 16'h0);
    chk(prescale_tick_out, 32'h0);
    bus(1'b1, A_RUN, 32'h0);
    cyc(2);
    chk(count_out, 32'h0);
    bus(1'b1, tmrctl_pkg::ADDR_PRESCALE, 32'h0);
  endtask : t_run
  // Control is only rewritten with the run bits cleared
  task automatic t_start();
    bus(1'b1, A_CR, 32'h3);
    bus(1'b1, A_RUN, 32'h5);
    chk(compare_buffered_out, 32'h0);
    idle_mode_in <= 1'b1;
    cyc(3);
    chk(channel_clk_en_out, 32'h0);
    idle_mode_in <= 1'b0;
    cyc(8);
    chk(count_out, 32'h0);
    timer_input_pin_in <= 1'b1;
    cyc(8);
    chk(count_out, 32'h0);
    timer_input_pin_in <= 1'b0;
    cyc(8);
    chk(count_out, 32'h6);
    bus(1'b1, A_RUN, 32'h0);
    bus(1'b1, A_CR, 32'h20);
    bus(1'b1, A_RUN, 32'h5);
    cyc(8);
    chk(count_out, 32'h0);
    sync_start_in <= 1'b1;
    cyc(8);
    chk(count_out, 32'h6);
    bus(1'b1, A_RUN, 32'h0);
    bus(1'b1, A_CR, 32'h1);
    bus(1'b1, A_RUN, 32'h5);
    cyc(8);
    chk(count_out, 32'h0);
    timer_input_pin_in <= 1'b1;
    cyc(8);
    chk(count_out, 32'h6);
  endtask : t_start
  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  initial begin
    cyc(8);
    arst_n_in <= 1'b1;
    t_regs();
    t_run();
    t_start();
    test_done();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    cyc(4000);
    error_cnt++;
    test_done();
  end
endmodule : tmrctl_tb
`default_nettype wire
